/* hdl/freq_sel_pkg.sv */
/*
 * Constants for the frequency reference conditioning block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes mclk at 100 MHz; frequencies are in steps of 0.01 Hz.
 */
package freq_sel_pkg;
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_NS         = 1000000;
   localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
   localparam int FW              = 16;
   localparam int MW              = 14;
   localparam int NTERM           = 5;
   localparam int NBAND           = 3;
   localparam int FUNC_W          = 6;
   localparam int CMD_W           = 3;
   localparam int FRQ_W           = 4;
   localparam int JUMP_SHIFT      = 3;

   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_LIMIT_LO   = 8'h04;
   localparam logic [7:0] ADDR_LIMIT_HI   = 8'h08;
   localparam logic [7:0] ADDR_JUMP_FIRST = 8'h0C;
   localparam logic [7:0] ADDR_JUMP_LAST  = 8'h20;
   localparam logic [7:0] ADDR_SRC        = 8'h24;
   localparam logic [7:0] ADDR_FUNC       = 8'h28;
   localparam logic [7:0] ADDR_FILTER     = 8'h2C;
   localparam logic [7:0] ADDR_CONTACT    = 8'h30;
   localparam logic [7:0] ADDR_STATUS     = 8'h34;
   localparam logic [7:0] ADDR_FREQ       = 8'h38;

   localparam int CTRL_LIMIT_EN = 0;
   localparam int CTRL_JUMP_EN  = 1;
   localparam int CTRL_RUN_NC   = 2;
   localparam int SRC_PCMD      = 0;
   localparam int SRC_PFRQ      = 4;
   localparam int SRC_ACMD      = 8;
   localparam int SRC_AFRQ      = 12;
   localparam int FILT_ON       = 0;
   localparam int FILT_OFF      = 16;
   localparam int STAT_ALT      = 8;
   localparam int STAT_FWD      = 9;
   localparam int STAT_REV      = 10;

   localparam logic [2:0]       CTRL_RST     = 3'h0;
   localparam logic [NTERM-1:0] CONTACT_RST  = 5'h00;
   localparam logic [FW-1:0]    MAX_FREQ_DEF = 16'h1770;
   localparam logic [FW-1:0]    LIMIT_LO_RST = 16'h0032;
   localparam logic [FW-1:0]    JUMP_LO_RST [NBAND] =
      '{16'h03E8, 16'h07D0, 16'h0BB8};
   localparam logic [FW-1:0]    JUMP_HI_RST [NBAND] =
      '{16'h05DC, 16'h09C4, 16'h0DAC};
   localparam logic [MW-1:0]    FILT_ON_RST  = 14'h000A;
   localparam logic [MW-1:0]    FILT_OFF_RST = 14'h0003;
   localparam logic [MW-1:0]    FILT_MAX     = 14'h2710;

   localparam logic [CMD_W-1:0] CMD_RST      = 3'h0;
   localparam logic [CMD_W-1:0] CMD_MAX      = 3'h4;
   localparam logic [CMD_W-1:0] CMD_KEYPAD   = 3'h0;
   localparam logic [CMD_W-1:0] CMD_TERM_FR  = 3'h1;
   localparam logic [CMD_W-1:0] CMD_TERM_DIR = 3'h2;
   localparam logic [FRQ_W-1:0] FRQ_RST      = 4'h0;
   localparam logic [FRQ_W-1:0] FRQ_MAX      = 4'h8;
   localparam logic [FRQ_W-1:0] FRQ_KEY_LAST = 4'h1;
   localparam logic [FRQ_W-1:0] FRQ_V_LAST   = 4'h4;
   localparam logic [FRQ_W-1:0] FRQ_I_LAST   = 4'h6;
   localparam logic [FUNC_W-1:0] FUNC_RST    = 6'h00;
   localparam logic [FUNC_W-1:0] FUNC_ALT    = 6'h0F;
   localparam logic [FUNC_W-1:0] FUNC_MAX    = 6'h34;
endpackage : freq_sel_pkg

/* hdl/input_debounce.sv */
/*
 * On/off filter for one multi-function input terminal.
 * Assumes din is already synchronised to mclk and tick is a one-cycle
 * pulse every millisecond from the same clock.
 */
module input_debounce
   import freq_sel_pkg::*;
#(
   parameter int WID = MW
) (
   input  wire logic           mclk,
   input  wire logic           rst_n,
   input  wire logic           tick,
   input  wire logic           din,
   input  wire logic [WID-1:0] on_ms,
   input  wire logic [WID-1:0] off_ms,
   output logic                level
);
   logic [WID-1:0] cnt;
   logic [WID-1:0] limit;

   assign limit = din ? on_ms : off_ms;

   // One tick more than the limit is counted, because the first tick
   // may arrive at once after the change.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         level <= 1'b0;
         cnt   <= '0;
      end else if (din == level) begin
         cnt <= '0;
      end else if (limit == '0 || cnt > limit) begin
         level <= din;
         cnt   <= '0;
      end else if (tick) begin
         cnt <= cnt + 1'b1;
      end
   end

   chk_filter_hold: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (din != level && limit != '0 && cnt <= limit)
      |=> level == $past(level))
      else $error("Input level changed before its filter time.");
endmodule : input_debounce

/* hdl/drive_freq_select.sv */
/*
 * Frequency reference conditioning for a motor drive: source select,
 * limit clamp, jump bands, input terminal filtering, register slave.
 * Assumes an Avalon-MM master on mclk and reference words on mclk;
 * terminal pins are asynchronous and are synchronised here.
 */
// Local design decisions: the Avalon-MM register port and the address map.
module drive_freq_select
   import freq_sel_pkg::*;
#(
   parameter int            TICK_CYCLES = TICK_CYCLES_DEF,
   parameter logic [FW-1:0] MAX_FREQ    = MAX_FREQ_DEF
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [7:0]       address,
   input  wire logic             read,
   input  wire logic             write,
   input  wire logic [31:0]      writedata,
   input  wire logic [3:0]       byteenable,
   output logic      [31:0]      readdata,
   output logic                  waitrequest,
   input  wire logic [NTERM-1:0] term_in,
   input  wire logic [1:0]       fwd_rev_run_inputs,
   input  wire logic [FW-1:0]    keypad_ref,
   input  wire logic [FW-1:0]    analog_voltage_input,
   input  wire logic [FW-1:0]    analog_current_input,
   input  wire logic [FW-1:0]    comm_ref,
   input  wire logic             keypad_fwd,
   input  wire logic             keypad_rev,
   input  wire logic             comm_fwd,
   input  wire logic             comm_rev,
   output logic      [FW-1:0]    freq_out,
   output logic                  run_fwd,
   output logic                  run_rev,
   output logic                  alt_source_select
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   logic                          rst_ff1;
   logic                          rst_q;
   logic [NTERM-1:0]              term_s1;
   logic [NTERM-1:0]              term_s2;
   logic [1:0]                    run_s1;
   logic [1:0]                    run_s2;
   logic [TW-1:0]                 tick_cnt;
   logic                          tick;
   logic                          limit_en;
   logic                          jump_en;
   logic                          run_nc;
   logic [FW-1:0]                 limit_lo;
   logic [FW-1:0]                 limit_hi;
   logic [FW-1:0]                 jump_lo [NBAND];
   logic [FW-1:0]                 jump_hi [NBAND];
   logic [CMD_W-1:0]              pri_cmd;
   logic [CMD_W-1:0]              alt_cmd;
   logic [FRQ_W-1:0]              pri_frq;
   logic [FRQ_W-1:0]              alt_frq;
   logic [NTERM-1:0][FUNC_W-1:0]  term_func;
   logic [MW-1:0]                 on_ms;
   logic [MW-1:0]                 off_ms;
   logic [NTERM-1:0]              contact;
   logic [NTERM-1:0]              term_status;
   logic [NTERM-1:0]              alt_hit;
   logic                          wr_go;
   logic                          rd_go;
   logic                          in_jump;
   logic [1:0]                    band;
   logic [31:0]                   reg_rd;
   logic [31:0]                   be_mask;
   logic [31:0]                   wmerge;
   logic [FW-1:0]                 wv;
   logic                          running;
   logic [CMD_W-1:0]              cmd_code;
   logic [FRQ_W-1:0]              frq_code;
   logic [1:0]                    run_lvl;
   logic                          next_fwd;
   logic                          next_rev;
   logic [FW-1:0]                 sel_ref;
   logic [FW-1:0]                 clamp_ref;
   logic [FW-1:0]                 next_freq;

   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_q);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_ff1 <= 1'b0;
         rst_q   <= 1'b0;
      end else begin
         rst_ff1 <= 1'b1;
         rst_q   <= rst_ff1;
      end
   end

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         term_s1 <= '0;
         term_s2 <= '0;
         run_s1  <= '0;
         run_s2  <= '0;
      end else begin
         term_s1 <= term_in;
         term_s2 <= term_s1;
         run_s1  <= fwd_rev_run_inputs;
         run_s2  <= run_s1;
      end
   end

   // A shared millisecond tick keeps the per-terminal counters narrow.
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick     <= 1'b0;
      end
   end

   assign wr_go   = write & ~waitrequest;
   assign rd_go   = read & waitrequest;
   assign in_jump = address >= ADDR_JUMP_FIRST &&
                    address <= ADDR_JUMP_LAST;
   assign band    = 2'((address - ADDR_JUMP_FIRST) >> JUMP_SHIFT);
   assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wmerge  = (reg_rd & ~be_mask) | (writedata & be_mask);
   assign wv      = wmerge[FW-1:0];
   assign running = run_fwd | run_rev;

   always_comb begin
      reg_rd = 32'h0000_0000;
      if (address == ADDR_CTRL) begin
         reg_rd[CTRL_LIMIT_EN] = limit_en;
         reg_rd[CTRL_JUMP_EN]  = jump_en;
         reg_rd[CTRL_RUN_NC]   = run_nc;
      end else if (address == ADDR_LIMIT_LO) begin
         reg_rd[FW-1:0] = limit_en ? limit_lo : '0;
      end else if (address == ADDR_LIMIT_HI) begin
         reg_rd[FW-1:0] = limit_en ? limit_hi : '0;
      end else if (in_jump) begin
         reg_rd[FW-1:0] = address[2] ? jump_lo[band] : jump_hi[band];
      end else if (address == ADDR_SRC) begin
         reg_rd[SRC_PCMD +: CMD_W] = pri_cmd;
         reg_rd[SRC_PFRQ +: FRQ_W] = pri_frq;
         reg_rd[SRC_ACMD +: CMD_W] = alt_cmd;
         reg_rd[SRC_AFRQ +: FRQ_W] = alt_frq;
      end else if (address == ADDR_FUNC) begin
         reg_rd[NTERM*FUNC_W-1:0] = term_func;
      end else if (address == ADDR_FILTER) begin
         reg_rd[FILT_ON +: MW]  = on_ms;
         reg_rd[FILT_OFF +: MW] = off_ms;
      end else if (address == ADDR_CONTACT) begin
         reg_rd[NTERM-1:0] = contact;
      end else if (address == ADDR_STATUS) begin
         reg_rd[NTERM-1:0] = term_status;
         reg_rd[STAT_ALT]  = alt_source_select;
         reg_rd[STAT_FWD]  = run_fwd;
         reg_rd[STAT_REV]  = run_rev;
      end else if (address == ADDR_FREQ) begin
         reg_rd[FW-1:0] = freq_out;
      end
   end

   // Every request sees exactly one wait cycle.
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (rd_go) begin
            readdata <= reg_rd;
         end
      end
   end

   chk_bus_ack: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("Bus request not answered after one wait cycle.");

   chk_hidden_read: assert property (
      rd_go && !limit_en &&
      (address == ADDR_LIMIT_LO || address == ADDR_LIMIT_HI)
      |=> readdata == 32'h0000_0000)
      else $error("Hidden limit register returned data.");

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         limit_en <= CTRL_RST[CTRL_LIMIT_EN];
         jump_en  <= CTRL_RST[CTRL_JUMP_EN];
         run_nc   <= CTRL_RST[CTRL_RUN_NC];
      end else if (wr_go && address == ADDR_CTRL) begin
         limit_en <= wmerge[CTRL_LIMIT_EN];
         jump_en  <= wmerge[CTRL_JUMP_EN];
         run_nc   <= wmerge[CTRL_RUN_NC];
      end
   end

   chk_ctrl_reset: assert property (
      $rose(rst_q) |-> !limit_en && !jump_en)
      else $error("Enable bits not off after reset.");

   // Out-of-range values are dropped, keeping lo <= hi <= maximum.
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         limit_lo <= LIMIT_LO_RST;
         limit_hi <= MAX_FREQ;
      end else if (wr_go && limit_en) begin
         if (address == ADDR_LIMIT_LO &&
             wv <= MAX_FREQ && wv <= limit_hi) begin
            limit_lo <= wv;
         end else if (address == ADDR_LIMIT_HI &&
                      wv >= limit_lo && wv <= MAX_FREQ) begin
            limit_hi <= wv;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         jump_lo <= JUMP_LO_RST;
         jump_hi <= JUMP_HI_RST;
      end else if (wr_go && in_jump) begin
         if (address[2]) begin
            if (wv <= jump_hi[band]) begin
               jump_lo[band] <= wv;
            end
         end else if (wv >= jump_lo[band] && wv <= MAX_FREQ) begin
            jump_hi[band] <= wv;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         pri_cmd <= CMD_RST;
         pri_frq <= FRQ_RST;
         alt_cmd <= CMD_RST;
         alt_frq <= FRQ_RST;
      end else if (wr_go && address == ADDR_SRC) begin
         if (wmerge[SRC_PCMD +: CMD_W] <= CMD_MAX) begin
            pri_cmd <= wmerge[SRC_PCMD +: CMD_W];
         end
         if (wmerge[SRC_PFRQ +: FRQ_W] <= FRQ_MAX) begin
            pri_frq <= wmerge[SRC_PFRQ +: FRQ_W];
         end
         if (!(running && !alt_source_select)) begin
            if (wmerge[SRC_ACMD +: CMD_W] <= CMD_MAX) begin
               alt_cmd <= wmerge[SRC_ACMD +: CMD_W];
            end
            if (wmerge[SRC_AFRQ +: FRQ_W] <= FRQ_MAX) begin
               alt_frq <= wmerge[SRC_AFRQ +: FRQ_W];
            end
         end
      end
   end

   chk_alt_lock: assert property (
      wr_go && address == ADDR_SRC && running && !alt_source_select
      |=> alt_cmd == $past(alt_cmd) && alt_frq == $past(alt_frq))
      else $error("Alternate source changed while running primary.");

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         term_func <= {NTERM{FUNC_RST}};
         on_ms     <= FILT_ON_RST;
         off_ms    <= FILT_OFF_RST;
         contact   <= CONTACT_RST;
      end else if (wr_go) begin
         if (address == ADDR_FUNC) begin
            for (int i = 0; i < NTERM; i++) begin
               if (wmerge[i*FUNC_W +: FUNC_W] <= FUNC_MAX) begin
                  term_func[i] <= wmerge[i*FUNC_W +: FUNC_W];
               end
            end
         end else if (address == ADDR_FILTER) begin
            if (wmerge[FILT_ON +: MW] <= FILT_MAX) begin
               on_ms <= wmerge[FILT_ON +: MW];
            end
            if (wmerge[FILT_OFF +: MW] <= FILT_MAX) begin
               off_ms <= wmerge[FILT_OFF +: MW];
            end
         end else if (address == ADDR_CONTACT) begin
            contact <= wmerge[NTERM-1:0];
         end
      end
   end

   genvar g;
   for (g = 0; g < NTERM; g++) begin : g_term
      input_debounce #(
         .WID (MW)
      ) u_deb (
         .mclk   (mclk),
         .rst_n  (rst_q),
         .tick   (tick),
         .din    (term_s2[g] ^ contact[g]),
         .on_ms  (on_ms),
         .off_ms (off_ms),
         .level  (term_status[g])
      );
      assign alt_hit[g] = term_status[g] &&
                          term_func[g] == FUNC_ALT;
   end

   chk_status_reset: assert property (
      $rose(rst_q) |-> term_status == '0 && contact == '0)
      else $error("Terminal status or selection not zero at reset.");

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         alt_source_select <= 1'b0;
      end else begin
         alt_source_select <= |alt_hit;
      end
   end

   // A normally-closed run contact reads active while the pin is low.
   assign run_lvl  = run_s2 ^ {2{run_nc}};
   assign cmd_code = alt_source_select ? alt_cmd : pri_cmd;
   assign frq_code = alt_source_select ? alt_frq : pri_frq;

   chk_alt_follow: assert property (
      alt_source_select && alt_frq > FRQ_I_LAST && !limit_en && !jump_en
      |=> freq_out == $past(comm_ref))
      else $error("Alternate source active but primary selected.");

   always_comb begin
      next_fwd = 1'b0;
      next_rev = 1'b0;
      case (cmd_code)
         CMD_KEYPAD: begin
            next_fwd = keypad_fwd & ~keypad_rev;
            next_rev = keypad_rev & ~keypad_fwd;
         end
         CMD_TERM_FR: begin
            next_fwd = run_lvl[0] & ~run_lvl[1];
            next_rev = run_lvl[1] & ~run_lvl[0];
         end
         CMD_TERM_DIR: begin
            next_fwd = run_lvl[0] & ~run_lvl[1];
            next_rev = run_lvl[0] & run_lvl[1];
         end
         default: begin
            next_fwd = comm_fwd & ~comm_rev;
            next_rev = comm_rev & ~comm_fwd;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         run_fwd <= 1'b0;
         run_rev <= 1'b0;
      end else begin
         run_fwd <= next_fwd;
         run_rev <= next_rev;
      end
   end

   always_comb begin
      if (frq_code <= FRQ_KEY_LAST) begin
         sel_ref = keypad_ref;
      end else if (frq_code <= FRQ_V_LAST) begin
         sel_ref = analog_voltage_input;
      end else if (frq_code <= FRQ_I_LAST) begin
         sel_ref = analog_current_input;
      end else begin
         sel_ref = comm_ref;
      end
   end

   // The clamp acts on every source, keypad included.
   always_comb begin
      clamp_ref = sel_ref;
      if (limit_en && sel_ref < limit_lo) begin
         clamp_ref = limit_lo;
      end else if (limit_en && sel_ref > limit_hi) begin
         clamp_ref = limit_hi;
      end
   end

   chk_limit_clamp: assert property (
      limit_en |-> clamp_ref >= limit_lo && clamp_ref <= limit_hi)
      else $error("Clamped reference outside the limits.");

   chk_keypad_clamp: assert property (
      limit_en && frq_code <= FRQ_KEY_LAST && keypad_ref > limit_hi
      |-> clamp_ref == limit_hi)
      else $error("Keypad reference escaped the upper limit.");

   // Jump bands act on the clamped value, so a held band edge can fall outside the limits.
   // The direction of approach is judged from the last output: from
   // below the low edge is held, from above the high edge.
   always_comb begin
      next_freq = clamp_ref;
      if (jump_en) begin
         for (int i = 0; i < NBAND; i++) begin
            if (next_freq > jump_lo[i] && next_freq < jump_hi[i]) begin
               if (freq_out >= jump_hi[i]) begin
                  next_freq = jump_hi[i];
               end else begin
                  next_freq = jump_lo[i];
               end
            end
         end
      end
   end

   // Once the reference leaves a band the output follows it in one
   // step, so the band is crossed without dwelling inside it.
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         freq_out <= '0;
      end else begin
         freq_out <= next_freq;
      end
   end

   for (g = 0; g < NBAND; g++) begin : g_band
      chk_jump_outside: assert property (
         jump_en |-> !(next_freq > jump_lo[g] &&
                       next_freq < jump_hi[g]))
         else $error("Output frequency inside a jump band.");
   end

   chk_jump_rise: assert property (
      jump_en && clamp_ref > jump_lo[0] && clamp_ref < jump_hi[0] &&
      freq_out <= jump_lo[0]
      |=> freq_out == $past(jump_lo[0]))
      else $error("Rising reference not held at band low edge.");

   chk_jump_fall: assert property (
      jump_en && clamp_ref > jump_lo[0] && clamp_ref < jump_hi[0] &&
      freq_out >= jump_hi[0]
      |=> freq_out == $past(jump_hi[0]))
      else $error("Falling reference not held at band high edge.");

   chk_pass_direct: assert property (
      !jump_en |=> freq_out == $past(clamp_ref))
      else $error("Output does not follow the clamped reference.");
endmodule : drive_freq_select

/* tb/ref_sources.sv */
/* Far-side sources: keypad and serial reference, run commands and
   terminal pins. Assumes the bench calls set; values move after mclk. */
module ref_sources
   import freq_sel_pkg::*;
(
   input  wire logic             mclk,
   output logic      [FW-1:0]    key_ref,
   output logic      [FW-1:0]    link_ref,
   output logic      [3:0]       cmds,
   output logic      [NTERM-1:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      key_ref = '0;
      link_ref = '0;
      cmds = '0;
      pins = '0;
   end
   task automatic set(input logic [FW-1:0] k, input logic [FW-1:0] c,
                      input logic [3:0] m, input logic [NTERM-1:0] p);
      @(posedge mclk);
      key_ref <= k;
      link_ref <= c;
      cmds <= m;
      pins <= p;
   endtask : set
endmodule : ref_sources

/* tb/test_drive_freq_select.sv */
/* Self-checking bench for drive_freq_select with a short ms tick.
   Assumes ref_sources as far side; the analogue inputs are held fixed. */
module test_drive_freq_select
   import freq_sel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             mclk = 1'b0;
   logic             rst_n = 1'b0;
   logic [7:0]       address = 8'h00;
   logic             read = 1'b0;
   logic             write = 1'b0;
   logic [31:0]      writedata = 32'h0;
   logic [31:0]      readdata, q;
   logic             waitrequest, run_fwd, run_rev, alt_source_select;
   logic [FW-1:0]    kref, cref, freq_out;
   logic [3:0]       cmds;
   logic [NTERM-1:0] pins;
   int               n_errors = 0;
   int               checks_done = 0;
   always #5 mclk = ~mclk;
   ref_sources src (.mclk(mclk), .key_ref(kref), .link_ref(cref),
      .cmds(cmds), .pins(pins));
   drive_freq_select #(.TICK_CYCLES(10)) dut_u (.mclk(mclk), .rst_n(rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .term_in(pins),
      .fwd_rev_run_inputs(cmds[1:0]), .keypad_ref(kref),
      .analog_voltage_input(16'h0111), .analog_current_input(16'h0222),
      .comm_ref(cref), .keypad_fwd(cmds[0]), .keypad_rev(cmds[1]),
      .comm_fwd(cmds[2]), .comm_rev(cmds[3]), .freq_out(freq_out),
      .run_fwd(run_fwd), .run_rev(run_rev),
      .alt_source_select(alt_source_select));
   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", w, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      chk("bus answer", 32'h2, n);
   endtask : bus
   task automatic rd(input string w, input logic [7:0] a,
                     input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(w, e, q);
   endtask : rd
   task automatic ref_chk(input string w, input logic [FW-1:0] k,
                          input logic [FW-1:0] e);
      src.set(k, 16'h1234, 4'h0, 5'h00);
      repeat (3) @(posedge mclk);
      chk(w, {16'h0, e}, {16'h0, freq_out});
   endtask : ref_chk
   task automatic t_reset();
      rd("ctrl", ADDR_CTRL, 32'h0);
      rd("hidden lo", ADDR_LIMIT_LO, 32'h0);
      bus(1'b1, ADDR_LIMIT_LO, 32'h0100);
      rd("status", ADDR_STATUS, 32'h0);
      rd("unmapped", 8'hFC, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_limit();
      bus(1'b1, ADDR_CTRL, 32'h1);
      rd("lo", ADDR_LIMIT_LO, {16'h0, LIMIT_LO_RST});
      rd("hi", ADDR_LIMIT_HI, {16'h0, MAX_FREQ_DEF});
      ref_chk("low clamp", 16'h0010, LIMIT_LO_RST);
      ref_chk("high clamp", 16'h2000, MAX_FREQ_DEF);
      bus(1'b1, ADDR_CTRL, 32'h0);
      $display("test limit done");
   endtask : t_limit
   task automatic t_jump();
      logic [FW-1:0] r [5] = '{16'h0300, 16'h0400, 16'h0600, 16'h0500,
                               16'h0100};
      logic [FW-1:0] e [5] = '{16'h0300, JUMP_LO_RST[0], 16'h0600,
                               JUMP_HI_RST[0], 16'h0100};
      bus(1'b1, ADDR_CTRL, 32'h2);
      for (int i = 0; i < 5; i++) begin
         ref_chk("jump", r[i], e[i]);
      end
      bus(1'b1, ADDR_CTRL, 32'h3);
      bus(1'b1, ADDR_LIMIT_LO, 32'h0400);
      ref_chk("clamp then jump", 16'h0100, JUMP_LO_RST[0]);
      bus(1'b1, ADDR_CTRL, 32'h0);
      $display("test jump done");
   endtask : t_jump
   task automatic t_polarity();
      bus(1'b1, ADDR_CTRL, 32'h4);
      bus(1'b1, ADDR_SRC, 32'h21);
      src.set(16'h0100, 16'h1234, 4'h2, 5'h00);
      repeat (5) @(posedge mclk);
      chk("nc run", 32'h1, {31'h0, run_fwd});
      chk("voltage ref", 32'h0111, {16'h0, freq_out});
      bus(1'b1, ADDR_SRC, 32'h0);
      repeat (2) @(posedge mclk);
      chk("keypad rev", 32'h1, {31'h0, run_rev});
      bus(1'b1, ADDR_CTRL, 32'h0);
      $display("test polarity done");
   endtask : t_polarity
   task automatic t_alt();
      src.set(16'h0100, 16'h1234, 4'h1, 5'h00);
      repeat (3) @(posedge mclk);
      chk("run primary", 32'h1, {31'h0, run_fwd});
      bus(1'b1, ADDR_SRC, 32'h7300);
      rd("src locked", ADDR_SRC, 32'h0);
      src.set(16'h0100, 16'h1234, 4'h4, 5'h00);
      bus(1'b1, ADDR_SRC, 32'h7300);
      bus(1'b1, ADDR_SRC, 32'h9500);
      rd("src", ADDR_SRC, 32'h7300);
      bus(1'b1, ADDR_FUNC, 32'h0F);
      src.set(16'h0100, 16'h1234, 4'h4, 5'h01);
      repeat (60) @(posedge mclk);
      chk("early alt", 32'h0, {31'h0, alt_source_select});
      for (int n = 0; n < 200 && alt_source_select !== 1'b1; n++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
      chk("alt", 32'h1, {31'h0, alt_source_select});
      chk("alt freq", 32'h1234, {16'h0, freq_out});
      rd("status alt", ADDR_STATUS, 32'h0301);
      bus(1'b1, ADDR_CONTACT, 32'h1);
      repeat (80) @(posedge mclk);
      chk("inverted", 32'h0, {31'h0, alt_source_select});
      $display("test alternate source done");
   endtask : t_alt
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_limit();
      t_jump();
      t_polarity();
      t_alt();
      complete_run();
   end
   // The tests need under 2000 cycles; ten times that means a hang.
   initial begin
      #200000;
      n_errors++;
      complete_run();
   end
endmodule : test_drive_freq_select
